// ### rtl/ctpf_clock_ctrl.sv
// Clock trim, protected prescaler and clock failure detector with safe-clock failover.
`timescale 1ns/1ps
module ctpf_clock_ctrl (
  // Clock and reset.
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Register port.
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // Fuses, static levels from the fuse array.
  input  wire logic       i_div8_fuse,
  input  wire logic       i_cfd_fuse,
  // Oscillator activity, asynchronous pins.
  input  wire logic       i_ext_osc_clk,
  input  wire logic       i_lf_osc_clk,
  // Power manager: high while in power-save or power-down sleep.
  input  wire logic       i_deep_sleep,
  // Oscillator and clock tree controls.
  output logic      [7:0] o_rc_trim,
  output logic            o_trim_range_select,
  output logic      [3:0] o_clock_source_select,
  output logic            o_rc_osc_en,
  output logic            o_lf_osc_en,
  output logic      [3:0] o_prescale_active,
  output logic            o_sys_clk_en,
  // Failure status.
  output logic            o_failure_detected,
  output logic            o_failure_irq
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Terminal count of the divider for a division code. Reserved codes run as
  // divide by 256, the slowest legal setting, so they can never overclock.
  function automatic logic [7:0] div_mask(input logic [3:0] code);
    logic [7:0] m;
    m = ctpf_pkg::MASK_MAX;
    if (code < ctpf_pkg::DIV_MAX) begin
      m = 8'((9'h001 << code) - 9'h001);
    end
    return m;
  endfunction : div_mask

  // State register, its next value and the bundled register request.

  ctpf_pkg::ctpf_state_s st_r;    // Registered state.
  ctpf_pkg::ctpf_state_s st_nxt;  // Next state.
  ctpf_pkg::ctpf_bus_s   bus;     // Bundled register request.

  // Decoded strobes, shared by the next-state logic and the checks.
  logic wr_pre;   // Write to the prescaler register.
  logic wr_fail;  // Write to the failure register.
  logic wr_trim;  // Write to the trim register.
  logic lf_rise;  // Rising edge of the 128 kHz clock.
  logic ext_rise; // Rising edge of the external clock.
  logic fail_now; // A dead 128 kHz window seen while monitoring.

  assign bus     = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};
  assign wr_pre  = bus.wr && (bus.addr == ctpf_pkg::ADDR_PRESCALE);
  assign wr_fail = bus.wr && (bus.addr == ctpf_pkg::ADDR_FAILURE);
  assign wr_trim = bus.wr && (bus.addr == ctpf_pkg::ADDR_TRIM);
  // Edges are taken from the second synchroniser stage onward only.
  assign lf_rise  = st_r.lf_sy[1] && !st_r.lf_prev;
  assign ext_rise = st_r.ext_sy[1] && !st_r.ext_prev;
  // Same decision as the monitor branch below; the checks use it to skip the
  // one cycle in which a failure overrides a register write.
  assign fail_now = (st_r.fsm == ctpf_pkg::ST_MONITOR) && !i_deep_sleep && lf_rise && !st_r.ext_seen;

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  // Everything the block remembers is computed here in one place.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;

    // Two-stage synchronisers; stage one feeds only stage two.
    st_nxt.ext_sy   = {st_r.ext_sy[0], i_ext_osc_clk};
    st_nxt.ext_prev = st_r.ext_sy[1];
    st_nxt.lf_sy    = {st_r.lf_sy[0], i_lf_osc_clk};
    st_nxt.lf_prev  = st_r.lf_sy[1];
    st_nxt.d8_sy    = {st_r.d8_sy[0], i_div8_fuse};
    st_nxt.cfd_sy   = {st_r.cfd_sy[0], i_cfd_fuse};

    // The 128 kHz oscillator follows the failure-detect fuse.
    st_nxt.osc128_en = st_r.cfd_sy[1];

    // Trim is a plain read-write byte; its bits drive the oscillator directly.
    if (wr_trim) begin
      st_nxt.trim = bus.wdata;
    end

    // Change window countdown; it closes by itself after four cycles.
    if (st_r.pce) begin
      if (st_r.pce_cnt == 3'h0) begin
        st_nxt.pce = 1'b0;
      end else begin
        st_nxt.pce_cnt = st_r.pce_cnt - 3'h1;
      end
    end

    // Prescaler register writes.
    if (wr_pre) begin
      if (bus.wdata == ctpf_pkg::PCE_UNLOCK) begin
        // Opening only; a rewrite while open is ignored.
        if (!st_r.pce) begin
          st_nxt.pce     = 1'b1;
          st_nxt.pce_cnt = ctpf_pkg::PCE_LAST;
        end
      end else if (st_r.pce && !bus.wdata[ctpf_pkg::PCE_BIT]) begin
        // Any code is taken, reserved ones included.
        st_nxt.div_sel = bus.wdata[3:0];
        st_nxt.pce     = 1'b0;
      end
    end

    // Interrupt enable can only be set by software.
    if (wr_fail && bus.wdata[ctpf_pkg::IE_BIT]) begin
      st_nxt.ie = 1'b1;
    end

    // An external edge marks the current window alive; the set beats the
    // window-end clear above so no edge is lost.
    if (lf_rise) begin
      st_nxt.ext_seen = 1'b0;
    end
    if (ext_rise) begin
      st_nxt.ext_seen = 1'b1;
    end

    // Detector state machine.
    unique case (st_r.fsm)
      ctpf_pkg::ST_BOOT: begin
        // Fuse levels are valid once the synchronisers have settled.
        if (st_r.boot_cnt == ctpf_pkg::BOOT_LAST) begin
          st_nxt.div_sel = st_r.d8_sy[1] ? ctpf_pkg::DIV_RESET_FUSED
                                         : ctpf_pkg::DIV_RESET_PLAIN;
          st_nxt.div_act = st_nxt.div_sel;
          st_nxt.fsm     = st_r.cfd_sy[1] ? ctpf_pkg::ST_STARTUP : ctpf_pkg::ST_OFF;
          st_nxt.start_cnt = ctpf_pkg::START_LAST;
        end else begin
          st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
        end
      end
      ctpf_pkg::ST_OFF: begin
        // Detection fused off; nothing to watch.
        st_nxt.fsm = ctpf_pkg::ST_OFF;
      end
      ctpf_pkg::ST_STARTUP: begin
        // Failures are not judged while the oscillator starts.
        if (i_deep_sleep) begin
          st_nxt.fsm = ctpf_pkg::ST_SLEEP;
        end else if (st_r.start_cnt == 9'h000) begin
          st_nxt.fsm      = ctpf_pkg::ST_MONITOR;
          st_nxt.ext_seen = 1'b1;  // Grace for the first partial window.
        end else begin
          st_nxt.start_cnt = st_r.start_cnt - 9'h001;
        end
      end
      ctpf_pkg::ST_MONITOR: begin
        if (i_deep_sleep) begin
          st_nxt.fsm = ctpf_pkg::ST_SLEEP;
        end else if (lf_rise && !st_r.ext_seen) begin
          // A whole 128 kHz period passed with no external edge.
          st_nxt.fsm     = ctpf_pkg::ST_FAILED;
          st_nxt.flag    = 1'b1;
          st_nxt.src     = ctpf_pkg::SRC_RC;
          st_nxt.rc_en   = 1'b1;
          st_nxt.div_sel = ctpf_pkg::DIV_FALLBACK;
          st_nxt.pce     = 1'b0;
        end
      end
      ctpf_pkg::ST_SLEEP: begin
        // Waking restarts the oscillator, so the start-up time runs again.
        if (!i_deep_sleep) begin
          st_nxt.fsm       = ctpf_pkg::ST_STARTUP;
          st_nxt.start_cnt = ctpf_pkg::START_LAST;
        end
      end
      ctpf_pkg::ST_FAILED: begin
        // Only reset leaves the safe clock; the fallback division is held.
        st_nxt.fsm     = ctpf_pkg::ST_FAILED;
        st_nxt.div_sel = ctpf_pkg::DIV_FALLBACK;
      end
      default: begin
        // An illegal code recovers by rebooting the detector.
        st_nxt.fsm      = ctpf_pkg::ST_BOOT;
        st_nxt.boot_cnt = 2'h0;
      end
    endcase

    // Divider: a new division takes effect only at the end of a full output
    // period, so no short pulse and no faster intermediate rate can appear.
    if (st_r.pre_cnt >= div_mask(st_r.div_act)) begin
      st_nxt.pre_cnt = 8'h00;
      st_nxt.tick    = 1'b1;
      st_nxt.div_act = st_nxt.div_sel;
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
    end

    // Interrupt follows the flag while enabled.
    st_nxt.irq = st_r.flag && st_r.ie;

    // Read data, valid in the cycle after the strobe only.
    st_nxt.rdata = ctpf_pkg::BYTE_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        ctpf_pkg::ADDR_PRESCALE: st_nxt.rdata = {st_r.pce, 3'h0, st_r.div_sel};
        ctpf_pkg::ADDR_FAILURE:  st_nxt.rdata = {6'h00, st_r.flag, st_r.ie};
        ctpf_pkg::ADDR_TRIM:     st_nxt.rdata = st_r.trim;
        default:                 st_nxt.rdata = ctpf_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  // Reset gives constants only; fuse-dependent values load after release.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r           <= '0;
      st_r.fsm       <= ctpf_pkg::ST_BOOT;
      st_r.trim      <= ctpf_pkg::TRIM_FACTORY;
      st_r.src       <= ctpf_pkg::SRC_EXT;
      st_r.div_sel   <= ctpf_pkg::DIV_RESET_PLAIN;
      st_r.div_act   <= ctpf_pkg::DIV_RESET_PLAIN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, straight from the state register.
  // ==========================================================================
  assign o_reg_rdata           = st_r.rdata;
  assign o_rc_trim             = st_r.trim;
  assign o_trim_range_select   = st_r.trim[ctpf_pkg::TRIM_RANGE];
  assign o_clock_source_select = st_r.src;
  assign o_rc_osc_en           = st_r.rc_en;
  assign o_lf_osc_en           = st_r.osc128_en;
  assign o_prescale_active     = st_r.div_act;
  assign o_sys_clk_en          = st_r.tick;
  assign o_failure_detected    = st_r.flag;
  assign o_failure_irq         = st_r.irq;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Steps of the change procedure.
  sequence s_unlock;
    wr_pre && (bus.wdata == ctpf_pkg::PCE_UNLOCK) && !st_r.pce && !fail_now;
  endsequence
  sequence s_code_write;
    wr_pre && st_r.pce && !bus.wdata[ctpf_pkg::PCE_BIT] && !fail_now
      && (st_r.fsm != ctpf_pkg::ST_FAILED) && (st_r.fsm != ctpf_pkg::ST_BOOT);
  endsequence

  a_pce_opens: assert property (s_unlock |=> st_r.pce && (st_r.pce_cnt == ctpf_pkg::PCE_LAST))
    else $error("change enable did not open");
  a_pce_closes: assert property ($rose(st_r.pce) |-> ##[1:4] !st_r.pce)
    else $error("change enable stayed open too long");
  a_pce_no_restart: assert property (st_r.pce && (st_r.pce_cnt != 3'h0) && wr_pre && !fail_now
      && (bus.wdata == ctpf_pkg::PCE_UNLOCK) |=> st_r.pce && (st_r.pce_cnt == $past(st_r.pce_cnt) - 3'h1))
    else $error("rewrite changed the change window");
  a_code_taken: assert property (s_code_write |=> (st_r.div_sel == $past(bus.wdata[3:0])) && !st_r.pce)
    else $error("division code not taken");
  // A write that finds the window closed must leave the field alone.
  a_code_locked: assert property (wr_pre && !st_r.pce && !fail_now
      && (st_r.fsm != ctpf_pkg::ST_BOOT) |=> $stable(st_r.div_sel))
    else $error("division changed while locked");
  a_fail_switch: assert property ($rose(st_r.flag) |-> (st_r.src == ctpf_pkg::SRC_RC) && st_r.rc_en
      && (st_r.div_sel == ctpf_pkg::DIV_FALLBACK))
    else $error("failure did not switch to safe clock");
  a_rc_only_failed: assert property (st_r.rc_en |-> st_r.flag && (st_r.fsm == ctpf_pkg::ST_FAILED))
    else $error("safe oscillator enabled without failure");
  a_flag_sticky: assert property (st_r.flag |=> st_r.flag && (st_r.src == ctpf_pkg::SRC_RC))
    else $error("failure flag or source released");
  a_ie_sticky: assert property (st_r.ie |=> st_r.ie)
    else $error("interrupt enable cleared");
  a_irq_follows: assert property (st_r.flag && st_r.ie |=> o_failure_irq)
    else $error("interrupt missing");
  a_startup_quiet: assert property (st_r.fsm == ctpf_pkg::ST_STARTUP |=> !$rose(st_r.flag))
    else $error("failure judged during start-up");
  a_sleep_suspend: assert property (i_deep_sleep && (st_r.fsm == ctpf_pkg::ST_MONITOR)
      && !lf_rise |=> st_r.fsm == ctpf_pkg::ST_SLEEP)
    else $error("monitoring not suspended in sleep");
  a_rsvd_zero: assert property (bus.rd && (bus.addr == ctpf_pkg::ADDR_FAILURE)
      |=> o_reg_rdata[7:2] == 6'h00)
    else $error("reserved bits read nonzero");
  a_div_at_period: assert property ($changed(st_r.div_act) && !$past(st_r.fsm == ctpf_pkg::ST_BOOT)
      |-> st_r.tick)
    else $error("division changed mid period");

  // ==========================================================================
  // Checks on reset loading, trim and the failover steps.
  // ==========================================================================
  // The reset division follows the fuse level seen at the end of boot.
  a_boot_div_load: assert property ((st_r.fsm == ctpf_pkg::ST_BOOT) && (st_r.boot_cnt == ctpf_pkg::BOOT_LAST)
      |=> st_r.div_sel == ($past(st_r.d8_sy[1]) ? ctpf_pkg::DIV_RESET_FUSED : ctpf_pkg::DIV_RESET_PLAIN))
    else $error("reset division ignored the fuse");

  // The slow oscillator enable tracks the synchronised detect fuse.
  a_lf_follows: assert property (o_lf_osc_en == $past(st_r.cfd_sy[1]))
    else $error("slow oscillator enable wrong");

  // Trim writes land whole, and nothing else moves the trim.
  a_trim_write: assert property (wr_trim |=> st_r.trim == $past(bus.wdata))
    else $error("trim write lost");
  a_trim_hold: assert property (!wr_trim |=> $stable(st_r.trim))
    else $error("trim moved without a write");

  // The window opens only from the exact unlock value.
  a_pce_only_unlock: assert property ($rose(st_r.pce) |-> $past(wr_pre && (bus.wdata == ctpf_pkg::PCE_UNLOCK)))
    else $error("change enable opened without unlock");

  // Failure steps: a dead window while monitoring, then the safe clock.
  // Sleep has priority, so a window that ends as sleep begins is not judged.
  sequence s_dead_window;
    fail_now;
  endsequence
  a_fail_detect: assert property (s_dead_window |=> st_r.flag && (st_r.fsm == ctpf_pkg::ST_FAILED)
      && (st_r.div_sel == ctpf_pkg::DIV_FALLBACK))
    else $error("dead window not flagged");

  // A failure is only ever judged from the monitor state.
  a_fail_from_monitor: assert property ($rose(st_r.flag) |-> $past(st_r.fsm) == ctpf_pkg::ST_MONITOR)
    else $error("failure judged outside monitoring");

  // Until a failure the external clock stays selected and the safe one off.
  a_src_ext_until_fail: assert property (!st_r.flag
      |-> (st_r.src == ctpf_pkg::SRC_EXT) && !st_r.rc_en)
    else $error("clock source left external without failure");

  // The interrupt never rises without both flag and enable.
  a_irq_needs_flag: assert property (o_failure_irq |-> $past(st_r.flag && st_r.ie))
    else $error("interrupt without flag and enable");

  // Read data stand only in the cycle after a read strobe.
  a_rdata_idle: assert property (!$past(bus.rd) |-> o_reg_rdata == ctpf_pkg::BYTE_ZERO)
    else $error("read data outside read cycle");

endmodule : ctpf_clock_ctrl

// ### rtl/ctpf_pkg.sv
// Shared constants, types and state layout for the clock trim, prescale and failover block.
package ctpf_pkg;

  // ==========================================================================
  // Register map, at the printed byte offsets of the plain register port.
  // ==========================================================================
  localparam logic [7:0] ADDR_PRESCALE = 8'h61;  // Prescaler control register.
  localparam logic [7:0] ADDR_FAILURE  = 8'h62;  // Failure control and status register.
  localparam logic [7:0] ADDR_TRIM     = 8'h66;  // RC oscillator trim register.

  // ==========================================================================
  // Field positions and values.
  // ==========================================================================
  localparam int         PCE_BIT      = 7;      // Change-enable bit of the prescaler register.
  localparam int         FLAG_BIT     = 1;      // Failure detected flag.
  localparam int         IE_BIT       = 0;      // Failure interrupt enable.
  localparam int         TRIM_RANGE   = 7;      // Trim range-select bit.
  localparam logic [7:0] PCE_UNLOCK   = 8'h80;  // Only value that opens the change window.
  localparam logic [7:0] TRIM_FACTORY = 8'h80;  // Stand-in factory calibration value.
  localparam logic [7:0] BYTE_ZERO    = 8'h00;  // Read value of unmapped space.

  // Division codes: 0 to 8 select divide by 1 to 256.
  localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;  // Reset code, divide-by-eight fuse clear.
  localparam logic [3:0] DIV_RESET_FUSED = 4'h3;  // Reset code, divide-by-eight fuse set.
  localparam logic [3:0] DIV_MAX         = 4'h8;  // Largest defined code.
  localparam logic [3:0] DIV_FALLBACK    = 4'h3;  // Brings the 8 MHz RC clock to 1 MHz.
  localparam logic [7:0] MASK_MAX        = 8'hFF; // Divider terminal count for divide by 256.

  // Clock source select codes.
  localparam logic [3:0] SRC_EXT = 4'h0;  // External oscillator clock.
  localparam logic [3:0] SRC_RC  = 4'h2;  // Calibrated RC oscillator, the safe clock.

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int         REF_PERIOD_NS   = 50;     // Reference clock period, 20 MHz.
  localparam int         PCE_WINDOW      = 4;      // Cycles the change-enable bit stays open.
  localparam logic [2:0] PCE_LAST        = 3'(PCE_WINDOW - 1);
  localparam logic [1:0] BOOT_LAST       = 2'h3;   // Lets the fuse synchronisers settle.
  localparam int         EXTERNAL_OSCILLATOR_CLOCK_STARTUP_NS = 16000;  // External oscillator start-up time.
  localparam int         STARTUP_CYCLES  = (EXTERNAL_OSCILLATOR_CLOCK_STARTUP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [8:0] START_LAST      = 9'(STARTUP_CYCLES - 1);

  // ==========================================================================
  // Types.
  // ==========================================================================
  // Detector state machine, one-hot.
  typedef enum logic [5:0] {
    ST_BOOT    = 6'h01,  // Waiting for the fuse levels after reset.
    ST_OFF     = 6'h02,  // Failure detection fused off.
    ST_STARTUP = 6'h04,  // External oscillator starting, failures ignored.
    ST_MONITOR = 6'h08,  // Watching the external clock.
    ST_SLEEP   = 6'h10,  // Deep sleep, monitoring suspended.
    ST_FAILED  = 6'h20   // Running on the safe clock until reset.
  } ctpf_fsm_e;

  // One register-port request.
  typedef struct packed {
    logic [7:0] addr;   // Byte address.
    logic [7:0] wdata;  // Write data.
    logic       wr;     // Write strobe.
    logic       rd;     // Read strobe.
  } ctpf_bus_s;

  // Whole state of the block.
  typedef struct packed {
    ctpf_fsm_e  fsm;        // Detector state.
    logic [1:0] boot_cnt;   // Boot settle counter.
    logic [8:0] start_cnt;  // Start-up countdown.
    logic       ext_seen;   // External edge seen in this 128 kHz window.
    logic [7:0] trim;       // RC oscillator trim.
    logic       pce;        // Change-enable bit.
    logic [2:0] pce_cnt;    // Cycles left in the change window.
    logic [3:0] div_sel;    // Division field as software sees it.
    logic [3:0] div_act;    // Division in force in the divider.
    logic [7:0] pre_cnt;    // Divider counter.
    logic       tick;       // System clock enable pulse.
    logic       flag;       // Failure detected flag.
    logic       ie;         // Failure interrupt enable.
    logic       irq;        // Interrupt output.
    logic [3:0] src;        // Clock source select.
    logic       rc_en;      // Safe RC oscillator enable.
    logic       osc128_en;  // 128 kHz oscillator enable.
    logic [7:0] rdata;      // Read data.
    logic [1:0] ext_sy;     // External clock synchroniser.
    logic       ext_prev;   // Last synchronised external level.
    logic [1:0] lf_sy;      // 128 kHz clock synchroniser.
    logic       lf_prev;    // Last synchronised 128 kHz level.
    logic [1:0] d8_sy;      // Divide-by-eight fuse synchroniser.
    logic [1:0] cfd_sy;     // Failure-detect fuse synchroniser.
  } ctpf_state_s;

endpackage : ctpf_pkg

// ### verif/ctpf_clock_ctrl_tb.sv
// Self-checking testbench for the clock trim, prescale and failover block.
`timescale 1ns/1ps
module ctpf_clock_ctrl_tb;
  // ==========================================================================
  // Signals and counters.
  // ==========================================================================
  logic       i_ref_clk = 1'b0, i_rst = 1'b1;  // Clock and reset.
  logic       i_reg_wr = 1'b0, i_reg_rd = 1'b0;  // Register strobes.
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_rc_trim;
  logic       i_div8_fuse = 1'b0, i_cfd_fuse = 1'b1, i_deep_sleep = 1'b0;
  logic       i_ext_osc_clk = 1'b0, i_lf_osc_clk = 1'b0, ext_run = 1'b1;
  logic       o_trim_range_select, o_rc_osc_en, o_lf_osc_en, o_sys_clk_en, o_failure_detected, o_failure_irq;
  logic [3:0] o_clock_source_select, o_prescale_active;
  int         num_errors = 0, checks = 0, lf_cnt = 0, cyc = 0;
  logic [7:0] d;  // Last read data.
  int         n;  // Wait counter.

  always #25 i_ref_clk = ~i_ref_clk;  // 20 MHz reference clock.

  // The external clock toggles every second cycle; a stopped one holds its level, as a dead crystal would.
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    lf_cnt <= (lf_cnt == 77) ? 0 : lf_cnt + 1;
    if (ext_run && cyc[0]) i_ext_osc_clk <= ~i_ext_osc_clk;
    if (lf_cnt == 77) i_lf_osc_clk <= ~i_lf_osc_clk;  // About 128 kHz.
  end

  ctpf_clock_ctrl dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_div8_fuse(i_div8_fuse),
    .i_cfd_fuse(i_cfd_fuse), .i_ext_osc_clk(i_ext_osc_clk), .i_lf_osc_clk(i_lf_osc_clk),
    .i_deep_sleep(i_deep_sleep), .o_rc_trim(o_rc_trim), .o_trim_range_select(o_trim_range_select),
    .o_clock_source_select(o_clock_source_select), .o_rc_osc_en(o_rc_osc_en), .o_lf_osc_en(o_lf_osc_en),
    .o_prescale_active(o_prescale_active), .o_sys_clk_en(o_sys_clk_en),
    .o_failure_detected(o_failure_detected), .o_failure_irq(o_failure_irq));

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  // Prints the counts and the verdict, then stops the run.
  task test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Compares one value against its expectation.
  task chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // A wait that used up its bound ends the run, since later steps would only cascade.
  task tmo(input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("[FAIL] wait bound used up");
      test_done;
    end
  endtask : tmo

  // One write cycle; the strobe drops at the edge that samples it.
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= v;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken in the single cycle that they stand.
  task rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd

  // Reset for five cycles, then let the fuse load settle.
  task do_reset;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask : do_reset

  // Unlock twice (second two cycles later), then write a code; gap 0 lands on the last open cycle.
  task win(input logic [7:0] code, input int gap, input logic [7:0] exp);
    wr(ctpf_pkg::ADDR_PRESCALE, ctpf_pkg::PCE_UNLOCK);
    wr(ctpf_pkg::ADDR_PRESCALE, ctpf_pkg::PCE_UNLOCK);
    repeat (gap) @(posedge i_ref_clk);
    wr(ctpf_pkg::ADDR_PRESCALE, code);
    rd(ctpf_pkg::ADDR_PRESCALE);
    chk("prescale", d, exp);
  endtask : win

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  // Reset values, trim range and unmapped space.
  task t_regs;
    chk("trim", o_rc_trim, ctpf_pkg::TRIM_FACTORY);
    rd(ctpf_pkg::ADDR_PRESCALE); chk("prescale", d, 8'h00);
    rd(ctpf_pkg::ADDR_FAILURE); chk("failure", d, 8'h00);
    wr(8'h63, 8'hFF); rd(8'h63); chk("unmapped", d, 8'h00);
    // No memory write runs here, so the high trim codes are safe to try.
    wr(ctpf_pkg::ADDR_TRIM, 8'h7F); rd(ctpf_pkg::ADDR_TRIM); chk("trim", d, 8'h7F);
    chk("range", o_trim_range_select, 1'b0); chk("trim out", o_rc_trim, 8'h7F);
    wr(ctpf_pkg::ADDR_TRIM, 8'h80); #1 chk("range", o_trim_range_select, 1'b1);
    $display("test regs done");
  endtask : t_regs

  // Protected prescaler writes, window edges and division periods.
  task t_prescale;
    wr(ctpf_pkg::ADDR_PRESCALE, 8'h05); wr(ctpf_pkg::ADDR_PRESCALE, 8'h81);
    wr(ctpf_pkg::ADDR_PRESCALE, 8'h01); rd(ctpf_pkg::ADDR_PRESCALE); chk("locked", d, 8'h00);
    win(8'h09, 0, 8'h09);
    win(8'h01, 1, 8'h09);
    for (int c = 2; c <= 8; c += 6) begin
      win(8'(c), 0, 8'(c));
      for (n = 0; n < 600 && o_prescale_active !== 4'(c); n++) begin @(posedge i_ref_clk); #1; end
      tmo(600);
      for (n = 0; n < 300 && o_sys_clk_en !== 1'b1; n++) begin @(posedge i_ref_clk); #1; end
      tmo(300);
      n = 0;
      do begin @(posedge i_ref_clk); #1 n++; end while (n < 300 && o_sys_clk_en !== 1'b1);
      chk("period", 9'(n), 9'(1 << c));
    end
    $display("test prescale done");
  endtask : t_prescale

  // Sleep suspends monitoring; a dead clock then fails over until reset.
  task t_failover;
    chk("lf en", o_lf_osc_en, 1'b1); chk("rc en", o_rc_osc_en, 1'b0);
    wr(ctpf_pkg::ADDR_FAILURE, 8'hFD); rd(ctpf_pkg::ADDR_FAILURE); chk("failure", d, 8'h01);
    @(posedge i_ref_clk); i_deep_sleep <= 1'b1; ext_run <= 1'b0;
    repeat (500) @(posedge i_ref_clk);
    #1 chk("sleep flag", o_failure_detected, 1'b0);
    @(posedge i_ref_clk); i_deep_sleep <= 1'b0;
    for (n = 0; n < 1500 && o_failure_detected !== 1'b1; n++) begin @(posedge i_ref_clk); #1; end
    tmo(1500);
    chk("startup", 9'(n >= 320), 9'h1);
    chk("source", o_clock_source_select, ctpf_pkg::SRC_RC); chk("rc en", o_rc_osc_en, 1'b1);
    wr(ctpf_pkg::ADDR_FAILURE, 8'h00); chk("irq", o_failure_irq, 1'b1);
    rd(ctpf_pkg::ADDR_FAILURE); chk("failure", d, 8'h03);
    win(8'h00, 0, 8'h03);
    @(posedge i_ref_clk); i_div8_fuse <= 1'b1; ext_run <= 1'b1;
    do_reset;
    chk("source", o_clock_source_select, ctpf_pkg::SRC_EXT); chk("flag", o_failure_detected, 1'b0);
    rd(ctpf_pkg::ADDR_PRESCALE); chk("fused div", d, 8'h03);
    @(posedge i_ref_clk); i_cfd_fuse <= 1'b0;
    do_reset; chk("lf off", o_lf_osc_en, 1'b0);
    $display("test failover done");
  endtask : t_failover

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    do_reset;
    t_regs;
    t_prescale;
    t_failover;
    test_done;
  end
endmodule : ctpf_clock_ctrl_tb
